/* File: src/slc_regs.sv */
// Register block for serial link loopback, calibration and overrides.
// Functional notes
// - pad loopback bit routes serial TX to RX.
// - core loopback returns TX data before pads.
// - watchdog stops calibration, applies default trim.
// - timeout disable bit turns watchdog off.
// - timeout select gives 32/48/64/128 microseconds.
// - averaging field repeats calibration 1/2/4/8 times.
// - start bit launches calibration, clears itself.
// - read-only bit shows recovery loop lock.
// - three override values apply when enabled.
// - six-bit read-only discharge event count.
// - delay codes reset to 9 and 6.
// - full 16-bit recovery test word.
// - indicator config resets to 2610 hex.
// - bit 8 at 41E enables overrides.
module slc_regs #(
	parameter int SER_W = 10
) (
	input wire logic aclk, // Device clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [slc_pkg::AXI_ADDR_W-1:0] awaddr, // Write address.
	input wire logic awvalid, // Write address valid.
	output logic awready, // Write address ready.
	input wire logic [31:0] wdata, // Write data.
	input wire logic [3:0] wstrb, // Write byte strobes.
	input wire logic wvalid, // Write data valid.
	output logic wready, // Write data ready.
	output logic [1:0] bresp, // Write response.
	output logic bvalid, // Write response valid.
	input wire logic bready, // Write response ready.
	input wire logic [slc_pkg::AXI_ADDR_W-1:0] araddr, // Read address.
	input wire logic arvalid, // Read address valid.
	output logic arready, // Read address ready.
	output logic [31:0] rdata, // Read data.
	output logic [1:0] rresp, // Read response.
	output logic rvalid, // Read data valid.
	input wire logic rready, // Read data ready.
	input wire logic [SER_W-1:0] ser_tx_data, // Serial transmit word.
	input wire logic [SER_W-1:0] ser_rx_pad_data, // Word from RX pads.
	output logic [SER_W-1:0] ser_rx_data, // Word into RX path.
	input wire logic recovery_locked, // Recovery loop lock.
	input wire logic data_sync, // Serial data sync status.
	input wire logic calib_step_done, // One tuning pass done, pulse.
	input wire logic [5:0] esd_count, // Discharge event count.
	input wire slc_pkg::slc_pwr_t pwr_func, // Functional power signals.
	output slc_pkg::slc_pwr_t pwr_o, // Power signals after override.
	output slc_pkg::slc_ana_t ana_o, // Front-end controls.
	output logic cal_busy, // Calibration running.
	output logic cal_default_trim, // Default trim in use.
	output logic irq // Level interrupt, active high.
);
	localparam int IW = slc_pkg::IDX_W;

	// Merges written bytes into a register, keeping read-only bits.
	function automatic logic [15:0] merge(logic [15:0] old,
		logic [15:0] wd, logic [15:0] m);
		return (old & ~m) | (wd & m);
	endfunction
	// True for every index that holds a register.
	function automatic logic is_mapped(logic [IW-1:0] idx);
		case (idx)
			slc_pkg::IDX_OVR_EN, slc_pkg::IDX_PAD, slc_pkg::IDX_TEST,
			slc_pkg::IDX_CORE, slc_pkg::IDX_CAL, slc_pkg::IDX_OVR_VAL,
			slc_pkg::IDX_DLY, slc_pkg::IDX_ESD, slc_pkg::IDX_LED,
			slc_pkg::IDX_IRQ_ST, slc_pkg::IDX_IRQ_MASK: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	// Watchdog limit in cycles for a select code.
	function automatic logic [11:0] wd_limit(logic [1:0] sel);
		case (sel)
			2'h0: return slc_pkg::WD_CYC_0;
			2'h1: return slc_pkg::WD_CYC_1;
			2'h2: return slc_pkg::WD_CYC_2;
			default: return slc_pkg::WD_CYC_3;
		endcase
	endfunction
	// Number of tuning passes for an averaging code.
	function automatic logic [3:0] avg_reps(logic [1:0] sel);
		return 4'(4'h1 << sel);
	endfunction
	logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff, cal_def_ff;
	logic [IW-1:0] wr_idx_ff, ar_idx;
	logic [15:0] wdata_ff, wr_bm, rd_val;
	logic [1:0] wstrb_ff, bresp_ff, rresp_ff, wd_sel, avg_sel;
	logic [31:0] rdata_ff;
	logic [15:0] ovr_en_ff, pad_ff, test_ff, core_ff, cal_ff;
	logic [15:0] ovr_val_ff, dly_ff, esd_ff, led_ff;
	logic [slc_pkg::IRQ_W-1:0] irq_st_ff, irq_mask_ff, irq_ev;
	logic [5:0] esd_prev_ff;
	slc_pkg::slc_cal_st_t cal_st_ff;
	logic [11:0] wd_cnt_ff;
	logic [3:0] rep_cnt_ff;
	slc_pkg::slc_pwr_t pwr_ff;
	logic [SER_W-1:0] rx_ff;
	logic wr_go, ar_fire, cal_start, cal_run, cal_fin, cal_tmo, wd_dis;
	// Bus handshakes; a pending response blocks new writes.
	assign awready = !aw_got_ff && !bvalid_ff;
	assign wready = !w_got_ff && !bvalid_ff;
	assign arready = !rvalid_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
	assign ar_fire = arvalid && arready;
	assign ar_idx = araddr[slc_pkg::AXI_ADDR_W-1:2];
	assign wr_bm = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

	// Write channel: address and data are taken in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= slc_pkg::RESP_OKAY;
			wr_idx_ff <= '0;
			wdata_ff <= 16'h0000;
			wstrb_ff <= 2'h0;
		end else begin
			if (awvalid && awready) begin
				aw_got_ff <= 1'b1;
				wr_idx_ff <= awaddr[slc_pkg::AXI_ADDR_W-1:2];
			end
			if (wvalid && wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= wdata[15:0];
				wstrb_ff <= wstrb[1:0];
			end
			if (wr_go) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= is_mapped(wr_idx_ff) ? slc_pkg::RESP_OKAY :
					slc_pkg::RESP_SLVERR;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Read value mux; bits above 15 and read-only gaps read as zero.
	always_comb begin
		rd_val = 16'h0000;
		case (ar_idx)
			slc_pkg::IDX_OVR_EN: rd_val = ovr_en_ff;
			slc_pkg::IDX_PAD: rd_val = pad_ff;
			slc_pkg::IDX_TEST: rd_val = test_ff;
			slc_pkg::IDX_CORE: rd_val = core_ff;
			slc_pkg::IDX_CAL: begin
				rd_val = cal_ff;
				rd_val[slc_pkg::CAL_START_BIT] = cal_run;
				rd_val[slc_pkg::CAL_LOCK_BIT] = recovery_locked;
				rd_val[slc_pkg::CAL_SYNC_BIT] = data_sync;
			end
			slc_pkg::IDX_OVR_VAL: rd_val = ovr_val_ff;
			slc_pkg::IDX_DLY: rd_val = dly_ff;
			slc_pkg::IDX_ESD: begin
				rd_val = esd_ff;
				rd_val[slc_pkg::ESD_LSB+:6] = esd_count;
			end
			slc_pkg::IDX_LED: rd_val = led_ff;
			slc_pkg::IDX_IRQ_ST: rd_val = {13'h0000, irq_st_ff};
			slc_pkg::IDX_IRQ_MASK: rd_val = {13'h0000, irq_mask_ff};
			default: rd_val = 16'h0000;
		endcase
	end

	// Read channel answers one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= slc_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= {16'h0000, rd_val};
			rresp_ff <= is_mapped(ar_idx) ? slc_pkg::RESP_OKAY :
				slc_pkg::RESP_SLVERR;
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// Configuration registers; reserved read-write bits simply store.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovr_en_ff <= slc_pkg::RST_ZERO;
			pad_ff <= slc_pkg::RST_PAD;
			test_ff <= slc_pkg::RST_ZERO;
			core_ff <= slc_pkg::RST_ZERO;
			cal_ff <= slc_pkg::RST_ZERO;
			ovr_val_ff <= slc_pkg::RST_ZERO;
			dly_ff <= slc_pkg::RST_DLY;
			esd_ff <= slc_pkg::RST_ZERO;
			led_ff <= slc_pkg::RST_LED;
		end else if (wr_go) begin
			case (wr_idx_ff)
				slc_pkg::IDX_OVR_EN: ovr_en_ff <= merge(ovr_en_ff, wdata_ff,
					wr_bm & slc_pkg::WM_OVR_EN);
				slc_pkg::IDX_PAD: pad_ff <= merge(pad_ff, wdata_ff,
					wr_bm);
				slc_pkg::IDX_TEST: test_ff <= merge(test_ff, wdata_ff,
					wr_bm);
				slc_pkg::IDX_CORE: core_ff <= merge(core_ff, wdata_ff,
					wr_bm);
				slc_pkg::IDX_CAL: cal_ff <= merge(cal_ff, wdata_ff,
					wr_bm & slc_pkg::WM_CAL);
				slc_pkg::IDX_OVR_VAL: ovr_val_ff <= merge(ovr_val_ff,
					wdata_ff, wr_bm);
				slc_pkg::IDX_DLY: dly_ff <= merge(dly_ff, wdata_ff,
					wr_bm & slc_pkg::WM_DLY);
				slc_pkg::IDX_ESD: esd_ff <= merge(esd_ff, wdata_ff,
					wr_bm & slc_pkg::WM_ESD);
				slc_pkg::IDX_LED: led_ff <= merge(led_ff, wdata_ff,
					wr_bm & slc_pkg::WM_LED);
				default: ;
			endcase
		end
	end
	// Front-end controls come straight from register flops.
	assign ana_o.pad_loopback_en = pad_ff[slc_pkg::PAD_LB_BIT];
	assign ana_o.core_loopback_enable = core_ff[slc_pkg::CORE_LB_BIT];
	assign ana_o.recovery_test_word = test_ff;
	assign ana_o.force_en = cal_ff[slc_pkg::CAL_FORCE_LSB+:4];
	assign ana_o.delay_line_en = dly_ff[slc_pkg::DLY_EN_BIT];
	assign ana_o.transmit_delay_code = dly_ff[slc_pkg::DLY_TX_LSB+:4];
	assign ana_o.receive_delay_code = dly_ff[slc_pkg::DLY_RX_LSB+:4];
	assign ana_o.led_cfg = led_ff[14:0];
	// Core loopback selects transmit data ahead of the pads.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_ff <= '0;
		end else begin
			rx_ff <= core_ff[slc_pkg::CORE_LB_BIT] ? ser_tx_data :
				ser_rx_pad_data;
		end
	end
	assign ser_rx_data = rx_ff;
	// Override bits 2, 1, 0 map onto the struct fields in that order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_ff <= '0;
		end else if (ovr_en_ff[slc_pkg::OVR_EN_BIT]) begin
			pwr_ff <= slc_pkg::slc_pwr_t'(ovr_val_ff[2:0]);
		end else begin
			pwr_ff <= pwr_func;
		end
	end
	assign pwr_o = pwr_ff;

	// Calibration sequencing terms; config is read live, so changes
	// made while a run is busy take effect at once.
	assign wd_dis = cal_ff[slc_pkg::CAL_WD_DIS_BIT];
	assign wd_sel = cal_ff[slc_pkg::CAL_WD_SEL_LSB+:2];
	assign avg_sel = cal_ff[slc_pkg::CAL_AVG_LSB+:2];
	assign cal_run = (cal_st_ff == slc_pkg::CAL_RUN);
	assign cal_start = wr_go && (wr_idx_ff == slc_pkg::IDX_CAL) &&
		wstrb_ff[0] && wdata_ff[slc_pkg::CAL_START_BIT];
	assign cal_fin = cal_run && calib_step_done &&
		(4'(rep_cnt_ff + 4'h1) == avg_reps(avg_sel));
	assign cal_tmo = cal_run && !cal_fin && !wd_dis &&
		(wd_cnt_ff == 12'(wd_limit(wd_sel) - 12'h001));
	// Calibration state machine with watchdog.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal_st_ff <= slc_pkg::CAL_IDLE;
			wd_cnt_ff <= 12'h000;
			rep_cnt_ff <= 4'h0;
			cal_def_ff <= 1'b0;
		end else begin
			case (cal_st_ff)
				slc_pkg::CAL_IDLE: begin
					if (cal_start) begin
						cal_st_ff <= slc_pkg::CAL_RUN;
						wd_cnt_ff <= 12'h000;
						rep_cnt_ff <= 4'h0;
					end
				end
				slc_pkg::CAL_RUN: begin
					wd_cnt_ff <= 12'(wd_cnt_ff + 12'h001);
					if (cal_fin) begin
						cal_st_ff <= slc_pkg::CAL_IDLE;
						cal_def_ff <= 1'b0;
					end else if (cal_tmo) begin
						cal_st_ff <= slc_pkg::CAL_IDLE;
						cal_def_ff <= 1'b1;
					end else if (calib_step_done) begin
						rep_cnt_ff <= 4'(rep_cnt_ff + 4'h1);
					end
				end
				default: cal_st_ff <= slc_pkg::CAL_IDLE;
			endcase
		end
	end
	assign cal_busy = cal_run;
	assign cal_default_trim = cal_def_ff;
	// Sticky events: a hardware set wins over a same-cycle clear.
	assign irq_ev = {(esd_count != esd_prev_ff), cal_tmo, cal_fin};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_ff <= '0;
			irq_mask_ff <= '0;
			esd_prev_ff <= 6'h00;
		end else begin
			esd_prev_ff <= esd_count;
			if (wr_go && wstrb_ff[0] && wr_idx_ff == slc_pkg::IDX_IRQ_ST) begin
				irq_st_ff <= (irq_st_ff & ~wdata_ff[2:0]) | irq_ev;
			end else begin
				irq_st_ff <= irq_st_ff | irq_ev;
			end
			if (wr_go && wstrb_ff[0] && wr_idx_ff == slc_pkg::IDX_IRQ_MASK) begin
				irq_mask_ff <= wdata_ff[2:0];
			end
		end
	end
	assign irq = |(irq_st_ff & irq_mask_ff);
	// Checks next to the logic they guard.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_pad_loopback_follows: assert property (
		wr_go && wr_idx_ff == slc_pkg::IDX_PAD && wstrb_ff[0] |=>
		ana_o.pad_loopback_en == $past(wdata_ff[slc_pkg::PAD_LB_BIT]))
		else $error("pad loopback enable did not follow write");
	a_core_loop_data: assert property (
		ana_o.core_loopback_enable |=> ser_rx_data == $past(ser_tx_data))
		else $error("core loopback did not return transmit data");
	a_cal_timeout_stop: assert property (
		cal_tmo |=> !cal_busy && cal_default_trim)
		else $error("watchdog expiry did not stop calibration");
	a_wd_disabled: assert property (
		cal_run && wd_dis |-> !cal_tmo)
		else $error("watchdog fired while disabled");
	a_wd_limit_value: assert property (
		cal_tmo |-> wd_cnt_ff + 12'h001 == wd_limit(wd_sel) &&
		(wd_sel != 2'h0 || wd_cnt_ff == 12'h27F))
		else $error("watchdog limit wrong");
	a_avg_passes: assert property (
		cal_fin && avg_sel == 2'h3 |-> rep_cnt_ff == 4'h7)
		else $error("averaging pass count wrong");
	a_start_sets_busy: assert property (
		cal_start && !cal_run |=> cal_busy)
		else $error("calibration start did not set busy");
	a_cal_self_clear: assert property (
		(cal_fin || cal_tmo) |=> !cal_busy)
		else $error("calibration busy did not clear");
	a_lock_readback: assert property (
		ar_fire && ar_idx == slc_pkg::IDX_CAL |=>
		rdata[slc_pkg::CAL_LOCK_BIT] == $past(recovery_locked))
		else $error("lock status misreported");
	a_override_applied: assert property (
		ovr_en_ff[slc_pkg::OVR_EN_BIT] && $stable(ovr_val_ff) |=>
		pwr_o == slc_pkg::slc_pwr_t'($past(ovr_val_ff[2:0])))
		else $error("override values not applied");
	a_override_off: assert property (
		!ovr_en_ff[slc_pkg::OVR_EN_BIT] |=> pwr_o == $past(pwr_func))
		else $error("functional power signals not passed");
	a_esd_readback: assert property (
		ar_fire && ar_idx == slc_pkg::IDX_ESD |=>
		rdata[slc_pkg::ESD_LSB+:6] == $past(esd_count))
		else $error("discharge count misreported");
	c_cal_finish: cover property (cal_fin);
	c_cal_timeout: cover property (cal_tmo);
	c_irq_raised: cover property ($rose(irq));
endmodule

/* File: common/slc_pkg.sv */
// Package with the map, layouts, timing and types of the serial link control block.
package slc_pkg;
	// Bus geometry: register index is the word address.
	localparam int AXI_ADDR_W = 14;
	localparam int IDX_W = 12;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register indices; byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_OVR_EN = 12'h41E;
	localparam logic [IDX_W-1:0] IDX_PAD = 12'h429;
	localparam logic [IDX_W-1:0] IDX_TEST = 12'h42B;
	localparam logic [IDX_W-1:0] IDX_CORE = 12'h42C;
	localparam logic [IDX_W-1:0] IDX_CAL = 12'h42E;
	localparam logic [IDX_W-1:0] IDX_OVR_VAL = 12'h42F;
	localparam logic [IDX_W-1:0] IDX_DLY = 12'h430;
	localparam logic [IDX_W-1:0] IDX_ESD = 12'h442;
	localparam logic [IDX_W-1:0] IDX_LED = 12'h450;
	localparam logic [IDX_W-1:0] IDX_IRQ_ST = 12'h460;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h461;

	// Reset values.
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_PAD = 16'h0030;
	localparam logic [15:0] RST_DLY = 16'h0960;
	localparam logic [15:0] RST_LED = 16'h2610;

	// Writable bit masks; other bits are read-only.
	localparam logic [15:0] WM_ALL = 16'hFFFF;
	localparam logic [15:0] WM_OVR_EN = 16'h01FF;
	localparam logic [15:0] WM_CAL = 16'h0F9E;
	localparam logic [15:0] WM_DLY = 16'h7FFF;
	localparam logic [15:0] WM_ESD = 16'h81FF;
	localparam logic [15:0] WM_LED = 16'h7FFF;

	// Field positions.
	localparam int OVR_EN_BIT = 8;
	localparam int PAD_LB_BIT = 1;
	localparam int CORE_LB_BIT = 4;
	localparam int CAL_WD_DIS_BIT = 11;
	localparam int CAL_WD_SEL_LSB = 9;
	localparam int CAL_AVG_LSB = 7;
	localparam int CAL_START_BIT = 6;
	localparam int CAL_LOCK_BIT = 5;
	localparam int CAL_FORCE_LSB = 1;
	localparam int CAL_SYNC_BIT = 0;
	localparam int DLY_EN_BIT = 12;
	localparam int DLY_TX_LSB = 8;
	localparam int DLY_RX_LSB = 4;
	localparam int ESD_LSB = 9;
	localparam int IRQ_W = 3;

	// Calibration watchdog limits in microseconds and in clock cycles.
	localparam int CLK_PERIOD_NS = 50;
	localparam int WD_US_0 = 32;
	localparam int WD_US_1 = 48;
	localparam int WD_US_2 = 64;
	localparam int WD_US_3 = 128;
	localparam logic [11:0] WD_CYC_0 = 12'(WD_US_0 * 1000 / CLK_PERIOD_NS);
	localparam logic [11:0] WD_CYC_1 = 12'(WD_US_1 * 1000 / CLK_PERIOD_NS);
	localparam logic [11:0] WD_CYC_2 = 12'(WD_US_2 * 1000 / CLK_PERIOD_NS);
	localparam logic [11:0] WD_CYC_3 = 12'(WD_US_3 * 1000 / CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_RUN = 2'b01
	} slc_cal_st_t;

	// Controls driven to the serial front end.
	typedef struct packed {
		logic pad_loopback_en;
		logic core_loopback_enable;
		logic [15:0] recovery_test_word;
		logic [3:0] force_en;
		logic delay_line_en;
		logic [3:0] transmit_delay_code;
		logic [3:0] receive_delay_code;
		logic [14:0] led_cfg;
	} slc_ana_t;

	// Power control signals that can be overridden.
	typedef struct packed {
		logic energy_lost;
		logic energy_detect_en;
		logic sleep_en;
	} slc_pwr_t;
endpackage

/* File: testbench/slc_mac_model.sv */
// Far-side serial traffic model with the pad-level return path.
module slc_mac_model #(
	parameter int SER_W = 10
) (
	input wire logic aclk, // Device clock.
	input wire logic pad_loopback_en, // Pad return path closed.
	output logic [SER_W-1:0] ser_tx_data, // Transmit word into the block.
	output logic [SER_W-1:0] ser_rx_pad_data // Word seen at the receive pads.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [SER_W-1:0] line_word;

	initial begin
		ser_tx_data = '0;
		line_word = '1;
	end

	// Both words change every cycle, so a stale word never passes for news.
	always @(posedge aclk) begin
		ser_tx_data <= ser_tx_data + 1'b1;
		line_word <= ser_tx_data ^ {SER_W{1'b1}};
	end

	// With the pad loop closed the pads carry the transmit word itself.
	assign ser_rx_pad_data = pad_loopback_en ? ser_tx_data : line_word;
endmodule

/* File: testbench/serial_mac_calib_loopback_ctrl_bench.sv */
// Self-checking bench for the serial link control register block.
module serial_mac_calib_loopback_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] RIDX [8] = '{slc_pkg::IDX_PAD, slc_pkg::IDX_TEST,
		slc_pkg::IDX_CORE, slc_pkg::IDX_CAL, slc_pkg::IDX_OVR_VAL,
		slc_pkg::IDX_DLY, slc_pkg::IDX_ESD, slc_pkg::IDX_LED};
	localparam logic [15:0] RRST [8] = '{16'h0030, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0960, 16'h0000, 16'h2610};
	localparam logic [15:0] RPAT [8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF,
		16'h0F9E, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	localparam logic [15:0] RBACK [8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF,
		16'h0F9E, 16'hFFFF, 16'h7FFF, 16'h81FF, 16'h7FFF};
	localparam int WD_US [4] = '{32, 48, 64, 128};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [13:0] awaddr = 14'h0000;
	logic [13:0] araddr = 14'h0000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp_q;
	logic [31:0] rdata, rd_q;
	logic [9:0] ser_tx_data, ser_rx_pad_data, ser_rx_data;
	logic recovery_locked = 1'b0;
	logic data_sync = 1'b0;
	logic calib_step_done = 1'b0;
	logic [5:0] esd_count = 6'h00;
	slc_pkg::slc_pwr_t pwr_func = 3'h0;
	slc_pkg::slc_pwr_t pwr_o;
	slc_pkg::slc_ana_t ana_o;
	logic cal_busy, cal_default_trim, irq;
	int num_errors = 0;
	int comparisons = 0;

	// Clock at 20 MHz.
	always #25 aclk = ~aclk;

	slc_regs #(.SER_W(10)) dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ser_tx_data(ser_tx_data), .ser_rx_pad_data(ser_rx_pad_data),
		.ser_rx_data(ser_rx_data), .recovery_locked(recovery_locked),
		.data_sync(data_sync), .calib_step_done(calib_step_done),
		.esd_count(esd_count), .pwr_func(pwr_func), .pwr_o(pwr_o),
		.ana_o(ana_o), .cal_busy(cal_busy),
		.cal_default_trim(cal_default_trim), .irq(irq));

	slc_mac_model #(.SER_W(10)) mac (.aclk(aclk),
		.pad_loopback_en(ana_o.pad_loopback_en), .ser_tx_data(ser_tx_data),
		.ser_rx_pad_data(ser_rx_pad_data));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Handshakes are judged mid-cycle, where they equal what the edge sees.
	task automatic wr(input logic [11:0] idx, input logic [15:0] d);
		logic a, w, b;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, d};
		wstrb <= 4'h3;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge aclk);
			a = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			resp_q = bresp;
			@(posedge aclk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] idx);
		logic a, r;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		r = 1'b0;
		while (!r) begin
			@(negedge aclk);
			a = arvalid && arready;
			r = rvalid;
			rd_q = rdata;
			resp_q = rresp;
			@(posedge aclk);
			if (a) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask

	task automatic pulse;
		@(posedge aclk);
		calib_step_done <= 1'b1;
		@(posedge aclk);
		calib_step_done <= 1'b0;
	endtask

	task automatic t_regs;
		for (int i = 0; i < 8; i++) begin
			rd(RIDX[i]);
			chk(rd_q, {16'h0000, RRST[i]}, "reset value");
		end
		for (int i = 0; i < 8; i++) begin
			wr(RIDX[i], RPAT[i]);
			rd(RIDX[i]);
			chk(rd_q, {16'h0000, RBACK[i]}, "readback");
		end
		chk(ana_o.recovery_test_word, 32'hFFFF, "test word");
		chk({ana_o.force_en, ana_o.delay_line_en}, 5'h1F,
			"front-end enables");
		for (int i = 0; i < 8; i++) wr(RIDX[i], RRST[i]);
		chk({ana_o.transmit_delay_code, ana_o.receive_delay_code}, 8'h96,
			"delay codes");
		chk(ana_o.led_cfg, 15'h2610, "lamp config");
		wr(slc_pkg::IDX_OVR_EN, 16'hFFFF);
		rd(slc_pkg::IDX_OVR_EN);
		chk(rd_q, 32'h01FF, "override enable word");
		wr(slc_pkg::IDX_OVR_EN, 16'h0000);
		wr(12'h431, 16'hFFFF);
		chk(resp_q, slc_pkg::RESP_SLVERR, "unmapped write");
		rd(12'h431);
		chk(rd_q, 32'h0, "unmapped read data");
		chk(resp_q, slc_pkg::RESP_SLVERR, "unmapped read");
	endtask

	// The expected word is the one offered at the edge before each look;
	// either loop must bring back the transmit word itself.
	task automatic t_loop(input logic pad, input logic core);
		logic [9:0] exp;
		wr(slc_pkg::IDX_PAD, {8'h00, 6'h0C, pad, 1'b0});
		wr(slc_pkg::IDX_CORE, {11'h000, core, 4'h0});
		chk(ana_o.pad_loopback_en, pad, "pad loop enable");
		@(negedge aclk);
		exp = (core || pad) ? ser_tx_data : ser_rx_pad_data;
		repeat (4) begin
			@(negedge aclk);
			chk(ser_rx_data, exp, "receive word");
			exp = (core || pad) ? ser_tx_data : ser_rx_pad_data;
		end
	endtask

	task automatic t_ovr;
		@(posedge aclk);
		pwr_func <= 3'h5;
		wr(slc_pkg::IDX_OVR_VAL, 16'h0002);
		repeat (2) @(negedge aclk);
		chk(pwr_o, 3'h5, "override off");
		wr(slc_pkg::IDX_OVR_EN, 16'h0100);
		repeat (2) @(negedge aclk);
		chk(pwr_o, 3'h2, "override on");
		wr(slc_pkg::IDX_OVR_EN, 16'h0000);
		repeat (2) @(negedge aclk);
		chk(pwr_o, 3'h5, "override released");
	endtask

	// Watchdog is off here, so only the pass count can end the run.
	task automatic t_cal(input logic [1:0] avg);
		int n;
		n = 1 << avg;
		@(posedge aclk);
		recovery_locked <= 1'b1;
		data_sync <= 1'b1;
		wr(slc_pkg::IDX_CAL, {4'h0, 1'b1, 2'b00, avg, 1'b1, 6'h00});
		rd(slc_pkg::IDX_CAL);
		chk(rd_q, {16'h0000, 4'h0, 1'b1, 2'b00, avg, 7'h61},
			"busy status");
		for (int i = 0; i < n; i++) begin
			pulse();
			repeat (2) @(negedge aclk);
			chk(cal_busy, i != n - 1, "pass count");
		end
		chk(cal_default_trim, 1'b0, "trim after finish");
		rd(slc_pkg::IDX_CAL);
		chk(rd_q, {16'h0000, 4'h0, 1'b1, 2'b00, avg, 7'h21},
			"self clear");
		recovery_locked <= 1'b0;
		data_sync <= 1'b0;
	endtask

	task automatic t_wd(input logic [1:0] sel);
		int cnt;
		int lim;
		lim = WD_US[sel] * 1000 / 50;
		// Busy already rose at the commit edge, one cycle before return.
		cnt = 1;
		wr(slc_pkg::IDX_CAL, {4'h0, 1'b0, sel, 2'b00, 1'b1, 6'h00});
		@(negedge aclk);
		while (cal_busy === 1'b1) begin
			cnt++;
			@(negedge aclk);
		end
		chk(cnt, lim, "watchdog limit");
		chk(cal_default_trim, 1'b1, "default trim");
	endtask

	task automatic t_wd_off;
		wr(slc_pkg::IDX_CAL, 16'h0840);
		repeat (700) @(negedge aclk);
		chk(cal_busy, 1'b1, "watchdog disabled");
		pulse();
		repeat (2) @(negedge aclk);
		chk({cal_busy, cal_default_trim}, 2'b00, "late finish");
	endtask

	task automatic t_irq;
		rd(slc_pkg::IDX_IRQ_ST);
		chk(rd_q, 32'h3, "finish and timeout events");
		esd_count <= 6'h2A;
		repeat (2) @(negedge aclk);
		rd(slc_pkg::IDX_ESD);
		chk(rd_q, 32'h5400, "discharge count");
		rd(slc_pkg::IDX_IRQ_ST);
		chk(rd_q, 32'h7, "all events");
		chk(irq, 1'b0, "masked event");
		wr(slc_pkg::IDX_IRQ_MASK, 16'h0004);
		chk(irq, 1'b1, "unmasked event");
		wr(slc_pkg::IDX_IRQ_ST, 16'h0007);
		rd(slc_pkg::IDX_IRQ_ST);
		chk(rd_q, 32'h0, "events cleared");
		chk(irq, 1'b0, "event cleared");
	endtask

	// Main sequence after a ten-cycle reset.
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({irq, cal_busy, cal_default_trim}, 3'h0, "outputs after reset");
		t_regs();
		t_loop(1'b0, 1'b0);
		t_loop(1'b1, 1'b0);
		t_loop(1'b0, 1'b1);
		t_loop(1'b1, 1'b1);
		t_ovr();
		for (int a = 0; a < 4; a++) t_cal(a[1:0]);
		for (int s = 0; s < 4; s++) t_wd(s[1:0]);
		t_wd_off();
		t_irq();
		end_sim();
	end

	// A hang counts as a mismatch once the expected run time is well past.
	initial begin
		#1500000;
		num_errors++;
		$display("[FAIL] %0t run did not finish in time", $time);
		end_sim();
	end
endmodule
